// ==== hw/tcp_pkg.sv ====
// Register map, field positions and constants of the test cell checker.
package tcp_pkg;
  // Register offsets on the 8-bit microprocessor port.
  localparam logic [7:0] ADDR_CTRL    = 8'h06;
  localparam logic [7:0] ADDR_HOLD    = 8'h07;
  localparam logic [7:0] ADDR_HDR1    = 8'h08;
  localparam logic [7:0] ADDR_HDR2    = 8'h09;
  localparam logic [7:0] ADDR_HDR3    = 8'h0A;
  localparam logic [7:0] ADDR_HDR4    = 8'h0B;
  localparam logic [7:0] ADDR_ERR_HI  = 8'h0C;
  localparam logic [7:0] ADDR_ERR_LO  = 8'h0D;

  // Control and status field positions.
  localparam int BIT_CLEAR_CH   = 7;
  localparam int BIT_GEN_ON     = 4;
  localparam int BIT_RSVD       = 3;
  localparam int BIT_BURST_SEL  = 2;
  localparam int BIT_BURST_DONE = 1;
  localparam int BIT_LOCK       = 0;

  // Reset values.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_HDR1 = 8'h00;
  localparam logic [7:0] RST_HDR2 = 8'h22;
  localparam logic [7:0] RST_HDR3 = 8'h33;
  localparam logic [7:0] RST_HDR4 = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'h00;

  // Cell layout and pattern constants.
  localparam int          CELL_BYTES   = 53;
  localparam int          HDR_BYTES    = 4;
  localparam int          PAYLOAD_FROM = 5;
  localparam int          BURST_CELLS  = 1024;
  localparam int          PRBS_LEN     = 15;
  localparam logic [14:0] PRBS_SEED    = 15'h7FFF;
  localparam int          LOCK_GOOD    = 8;
  localparam int          LOCK_BAD     = 8;

  // Generator states.
  typedef enum logic [1:0] {
    GEN_IDLE,
    GEN_CELL,
    GEN_RAW
  } tcp_gen_state_t;

  // One byte of x^15 + x^14 + 1, msb first; with use_in the state takes the
  // received bits instead of its own, which is how the checker seeds itself.
  function automatic logic [22:0] tcp_prbs_byte(input logic [14:0] st,
                                                input logic [7:0]  din,
                                                input logic        use_in);
    logic [14:0] s;
    logic [7:0]  p;
    logic        b;
    s = st;
    p = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b    = s[14] ^ s[13];
      p[i] = b;
      s    = {s[13:0], use_in ? din[i] : b};
    end
    return {p, s};
  endfunction : tcp_prbs_byte
endpackage : tcp_pkg

// ==== hw/tcp_top.sv ====
// Test cell and raw pattern generator and checker with its register file.
`timescale 1ns/1ps

// Synchronous FIFO of flip-flops; the generator stalls on its in_ready.
module tcp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("tcp_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
      count_q  <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tcp_fifo

// How it works
// - Cell mode enable inserts test cells; checker compares payload to PRBS.
// - Clear-channel enable inserts raw PRBS; the checker searches and locks.
// - Burst select low: cells go out continuously while enable stays high.
// - Burst select high: each enable rise generates exactly 1024 cells.
// - Burst-complete reads 0 during a burst and 1 once it finished.
// - Burst-complete clears when a new burst starts on enable rising edge.
// - Burst-complete only has meaning in cell mode with burst operation.
// - Lock flag reads 0 until checker locks, then 1, in both modes.
// - Bit errors are counted only while the checker is locked.
// - 16-bit error count in two bytes, cleared to zero when read.
// - Reading one count byte copies the other byte into the holding register.
// - Each test cell carries the four software-programmed header bytes.
// - Header byte two resets to 0x22, header byte three to 0x33.
// - Control bit 7 selects cell mode (0) or clear-channel mode (1).
module tcp_top
  import tcp_pkg::*;
#(
  parameter int FIFO_DEPTH  = 16,
  parameter int BURST_COUNT = tcp_pkg::BURST_CELLS
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] tx_data,
  output logic            tx_sof,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_sof,
  input  wire logic       rx_valid
);
  import tcp_pkg::*;

  generate
    if (BURST_COUNT < 1 || BURST_COUNT > 2047) begin : g_bad_burst
      $error("tcp_top burst count must lie in 1 to 2047");
    end
  endgenerate

  // Register file.
  logic [7:0]  ctrl_q;
  logic [7:0]  hdr_q [HDR_BYTES];
  logic [7:0]  hold_q;
  logic [7:0]  rdata_q;
  logic [15:0] err_q;
  logic        done_q;
  logic        lock_q;
  logic        gen_on_q;

  wire        wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL);
  wire        rd_err_hi = reg_rd && (reg_addr == ADDR_ERR_HI);
  wire        rd_err_lo = reg_rd && (reg_addr == ADDR_ERR_LO);
  wire        clear_ch  = ctrl_q[BIT_CLEAR_CH];
  wire        gen_on    = ctrl_q[BIT_GEN_ON];
  wire        burst_sel = ctrl_q[BIT_BURST_SEL];
  wire        gen_rise  = gen_on && !gen_on_q;
  // Status shows the flops as they stand: after a control write, lock and
  // done settle on the next edge, so read them two cycles after the write.
  wire [7:0]  status    = {ctrl_q[7], 2'b00, ctrl_q[4:2], done_q, lock_q};

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      ADDR_CTRL:   rd_mux = status;
      ADDR_HOLD:   rd_mux = hold_q;
      ADDR_HDR1:   rd_mux = hdr_q[0];
      ADDR_HDR2:   rd_mux = hdr_q[1];
      ADDR_HDR3:   rd_mux = hdr_q[2];
      ADDR_HDR4:   rd_mux = hdr_q[3];
      ADDR_ERR_HI: rd_mux = err_q[15:8];
      ADDR_ERR_LO: rd_mux = err_q[7:0];
      default:     rd_mux = 8'h00;
    endcase
  end

  assign reg_rdata = rdata_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q   <= RST_CTRL;
      hdr_q[0] <= RST_HDR1;
      hdr_q[1] <= RST_HDR2;
      hdr_q[2] <= RST_HDR3;
      hdr_q[3] <= RST_HDR4;
      rdata_q  <= 8'h00;
      gen_on_q <= 1'b0;
    end else begin
      gen_on_q <= gen_on;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_q <= {reg_wdata[7], 2'b00, reg_wdata[4:3], reg_wdata[2], 2'b00};
      end
      for (int i = 0; i < HDR_BYTES; i++) begin
        if (reg_wr && reg_addr == ADDR_HDR1 + 8'(i)) begin
          hdr_q[i] <= reg_wdata;
        end
      end
    end
  end

  // Generator.
  tcp_gen_state_t gen_state_q;
  logic [5:0]     gen_idx_q;
  logic [10:0]    cells_left_q;
  logic [14:0]    gen_prbs_q;
  logic           fifo_in_ready;
  logic [8:0]     fifo_out;

  // Generator and checker share one pattern function, so the two sides
  // can never drift onto different polynomials.
  wire [22:0] gen_step   = tcp_prbs_byte(gen_prbs_q, 8'h00, 1'b0);
  wire [7:0]  hec_byte   = hdr_q[0] ^ hdr_q[1] ^ hdr_q[2] ^ hdr_q[3];
  wire        gen_push   = (gen_state_q != GEN_IDLE) && fifo_in_ready;
  wire        in_payload = (gen_state_q == GEN_RAW) ||
                           (gen_idx_q >= 6'(PAYLOAD_FROM));
  wire        cell_last  = (gen_idx_q == 6'(CELL_BYTES - 1));
  wire        cell_end   = gen_push && (gen_state_q == GEN_CELL) && cell_last;
  wire        may_start  = gen_on && !clear_ch &&
                           (!burst_sel || cells_left_q != '0);

  logic [7:0] gen_byte;
  always_comb begin
    gen_byte = gen_step[22:15];
    if (gen_state_q == GEN_CELL && gen_idx_q < 6'(HDR_BYTES)) begin
      gen_byte = hdr_q[gen_idx_q[1:0]];
    end else if (gen_state_q == GEN_CELL && gen_idx_q == 6'(HDR_BYTES)) begin
      gen_byte = hec_byte;
    end
  end

  wire gen_sof = (gen_state_q == GEN_CELL) && (gen_idx_q == '0);

  // A cell in progress is always finished so the line never sees a runt.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gen_state_q <= GEN_IDLE;
      gen_idx_q   <= '0;
      gen_prbs_q  <= PRBS_SEED;
    end else begin
      if (gen_push && in_payload) begin
        gen_prbs_q <= gen_step[14:0];
      end
      case (gen_state_q)
        GEN_IDLE: begin
          gen_idx_q <= '0;
          if (gen_on && clear_ch) begin
            gen_state_q <= GEN_RAW;
          end else if (may_start && !(gen_rise && burst_sel)) begin
            gen_state_q <= GEN_CELL;
          end
        end
        GEN_CELL: begin
          if (gen_push) begin
            gen_idx_q <= cell_last ? '0 : gen_idx_q + 6'd1;
          end
          if (cell_end &&
              !(may_start && !(burst_sel && cells_left_q == 11'd1))) begin
            gen_state_q <= GEN_IDLE;
          end
        end
        GEN_RAW: begin
          if (!gen_on || !clear_ch) begin
            gen_state_q <= GEN_IDLE;
          end
        end
        default: gen_state_q <= GEN_IDLE;
      endcase
    end
  end

  // Burst bookkeeping; the done flag only means something in cell burst use.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cells_left_q <= '0;
      done_q       <= 1'b0;
    end else if (gen_rise && burst_sel && !clear_ch) begin
      cells_left_q <= 11'(BURST_COUNT);
      done_q       <= 1'b0;
    end else if (cell_end && burst_sel && cells_left_q != '0) begin
      cells_left_q <= cells_left_q - 11'd1;
      done_q       <= (cells_left_q == 11'd1);
    end
  end

  tcp_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   ({gen_sof, gen_byte}),
    .in_valid  (gen_state_q != GEN_IDLE),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  assign tx_data = fifo_out[7:0];
  assign tx_sof  = fifo_out[8];

  // Checker.
  logic [5:0]  rx_idx_q;
  logic        hdr_ok_q;
  logic [14:0] chk_prbs_q;
  logic [3:0]  good_q;
  logic [3:0]  bad_q;

  wire [5:0]  rx_idx     = rx_sof ? 6'd0 : rx_idx_q;
  wire        hdr_byte   = rx_idx < 6'(HDR_BYTES);
  wire        hdr_match  = (rx_data == hdr_q[rx_idx[1:0]]);
  // Byte five of a cell is the header check byte and is not compared; only
  // payload bytes of a cell whose four header bytes matched feed the checker.
  wire        chk_byte   = rx_valid && gen_on &&
                           (clear_ch || (hdr_ok_q &&
                           rx_idx >= 6'(PAYLOAD_FROM) &&
                           rx_idx < 6'(CELL_BYTES)));
  wire [22:0] chk_step   = tcp_prbs_byte(chk_prbs_q, rx_data, !lock_q);
  wire [7:0]  diff       = rx_data ^ chk_step[22:15];

  // Bit errors in one byte, up to eight, added to the count while locked.
  logic [3:0] nerr;
  always_comb begin
    nerr = 4'd0;
    for (int i = 0; i < 8; i++) begin
      nerr = nerr + 4'(diff[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_idx_q <= '0;
      hdr_ok_q <= 1'b0;
    end else if (rx_valid) begin
      rx_idx_q <= (rx_idx == 6'(CELL_BYTES - 1)) ? '0 : rx_idx + 6'd1;
      if (hdr_byte) begin
        hdr_ok_q <= hdr_match && (rx_idx == '0 || hdr_ok_q);
      end
    end
  end

  // Unlocked, the checker reseeds from received bits; locked, it free runs.
  always_ff @(posedge clk) begin
    if (sys_rst || !gen_on) begin
      chk_prbs_q <= PRBS_SEED;
      good_q     <= '0;
      bad_q      <= '0;
      lock_q     <= 1'b0;
    end else if (chk_byte) begin
      chk_prbs_q <= chk_step[14:0];
      if (!lock_q) begin
        good_q <= (diff == 8'h00) ? good_q + 4'd1 : 4'd0;
        lock_q <= (diff == 8'h00) && (good_q == 4'(LOCK_GOOD - 1));
      end else begin
        bad_q  <= (diff != 8'h00) ? bad_q + 4'd1 : 4'd0;
        lock_q <= !((diff != 8'h00) && (bad_q == 4'(LOCK_BAD - 1)));
        good_q <= '0;
      end
    end
  end

  // Error accumulator; errors landing in the read cycle start the new count.
  wire        count_now = chk_byte && lock_q;
  wire [15:0] err_add   = count_now ? 16'(nerr) : 16'h0000;
  wire [16:0] err_sum   = {1'b0, err_q} + {1'b0, err_add};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_q  <= 16'h0000;
      hold_q <= RST_HOLD;
    end else if (rd_err_hi || rd_err_lo) begin
      err_q  <= err_add;
      hold_q <= rd_err_hi ? err_q[7:0] : err_q[15:8];
    end else begin
      // The count saturates rather than wrap, so a flood of errors never
      // reads back as a small number.
      err_q  <= err_sum[16] ? 16'hFFFF : err_sum[15:0];
    end
  end
endmodule : tcp_top

// ==== hw/unused_placeholder_none.sv ====
// Intentionally empty file kept for compile order of the design.
`timescale 1ns/1ps

// ==== tb/tcp_line_model.sv ====
// Far-end line model that loops the outbound stream back inbound.
`timescale 1ns/1ps
module tcp_line_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       stall,
  input  wire logic [7:0] flip,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_sof,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_sof,
  output logic            rx_valid
);
  logic take;
  assign tx_ready = !stall;
  assign take     = tx_valid && tx_ready;
  // Between bytes the data lines toggle so stale values never look valid.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_valid <= 1'b0;
      rx_sof   <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      rx_valid <= take;
      rx_sof   <= take && tx_sof;
      rx_data  <= take ? (tx_data ^ flip) : ~rx_data;
    end
  end
endmodule : tcp_line_model

// ==== tb/tcp_top_sva.sv ====
// Concurrent checks on the register port and outbound stream.
`timescale 1ns/1ps
module tcp_top_sva
  import tcp_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] tx_data,
  input wire logic       tx_sof,
  input wire logic       tx_valid,
  input wire logic       tx_ready
);
  logic on_q;
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = reg_wr && reg_addr == ADDR_CTRL;
  assign ctl_rd = reg_rd && reg_addr == ADDR_CTRL;
  always_ff @(posedge clk) begin
    if (sys_rst) on_q <= 1'b0;
    else if (ctl_wr) on_q <= reg_wdata[BIT_GEN_ON];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_reset_quiet: assert property (
    $fell(sys_rst) |-> !tx_valid && reg_rdata == 8'h00)
    else $error("not idle after reset");
  chk_first_cell: assert property (
    ctl_wr && reg_wdata[BIT_GEN_ON] && !reg_wdata[BIT_CLEAR_CH] && !on_q
    && !tx_valid |-> ##[1:4] tx_valid && tx_sof)
    else $error("no cell start after enable");
  chk_done_clears: assert property (
    ctl_wr && reg_wdata[BIT_GEN_ON] && reg_wdata[BIT_BURST_SEL] && !on_q
    && !reg_wdata[BIT_CLEAR_CH] ##2 ctl_rd
    |=> !reg_rdata[BIT_BURST_DONE])
    else $error("done not cleared by new burst");
  chk_lock_drops: assert property (
    ctl_wr && !reg_wdata[BIT_GEN_ON] ##2 ctl_rd |=> !reg_rdata[BIT_LOCK])
    else $error("lock kept after disable");
  chk_ctrl_spare: assert property (
    ctl_rd |=> reg_rdata[6:5] == 2'b00)
    else $error("spare control bits set");
  chk_hdr_echo: assert property (
    reg_wr && reg_addr inside {[ADDR_HDR1:ADDR_HDR4]}
    ##1 reg_rd && reg_addr == $past(reg_addr)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("header not kept");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr > ADDR_ERR_LO |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_stall_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_sof))
    else $error("byte lost on stall");
  chk_rdata_stands: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule : tcp_top_sva

bind tcp_top tcp_top_sva chk_u (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_data(tx_data),
  .tx_sof(tx_sof), .tx_valid(tx_valid), .tx_ready(tx_ready));

// ==== tb/tcp_top_tb.sv ====
// Self-checking bench of tcp_top with its line looped back.
`timescale 1ns/1ps
module tcp_top_tb;
  import tcp_pkg::*;
  localparam int NB = 3;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] flip = 8'h00;
  logic       stall = 1'b0;
  logic [7:0] reg_rdata, tx_data, rx_data, v;
  logic       tx_sof, tx_valid, tx_ready, rx_sof, rx_valid;
  logic [7:0] hb [5];
  int         nb, ns, bad_count, samples_checked;

  always #12.5 clk = ~clk;

  tcp_top #(.FIFO_DEPTH(16), .BURST_COUNT(NB)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_data(tx_data), .tx_sof(tx_sof), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_sof(rx_sof),
    .rx_valid(rx_valid));
  tcp_line_model line_u (.clk(clk), .sys_rst(sys_rst), .stall(stall),
    .flip(flip), .tx_data(tx_data), .tx_sof(tx_sof),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_sof(rx_sof), .rx_valid(rx_valid));

  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      if (nb < 5) hb[nb] = tx_data;
      nb++;
      if (tx_sof) ns++;
    end
  end

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobes stay up between back-to-back accesses; idle drops them.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rc

  task automatic idle(input int n);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic wait_bytes(input int n);
    for (int i = 0; i < 4000 && nb < n; i++) @(negedge clk);
    if (nb < n) begin
      bad_count++;
      $display("Error at %0t: stream stalled", $time);
      finish_test();
    end
  endtask : wait_bytes

  task automatic t_reset;
    logic [7:0] a [8] = '{ADDR_CTRL, ADDR_HOLD, ADDR_HDR1, ADDR_HDR2,
                          ADDR_HDR3, ADDR_HDR4, ADDR_ERR_HI, ADDR_ERR_LO};
    logic [7:0] e [8] = '{RST_CTRL, RST_HOLD, RST_HDR1, RST_HDR2,
                          RST_HDR3, RST_HDR4, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rc(a[i], e[i]);
  endtask : t_reset

  task automatic t_regs;
    logic [7:0] h [4] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C};
    for (int i = 0; i < 4; i++) begin
      wr(8'(ADDR_HDR1 + i), h[i]);
      rc(8'(ADDR_HDR1 + i), h[i]);
    end
    wr(ADDR_HOLD, 8'hFF);
    rc(ADDR_HOLD, 8'h00);
    wr(ADDR_ERR_HI, 8'hFF);
    rc(ADDR_ERR_HI, 8'h00);
    rc(8'h20, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    rc(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h00);
    idle(2);
  endtask : t_regs

  // The line stalls first, so the FIFO fills and the generator must wait.
  task automatic t_burst;
    nb = 0;
    ns = 0;
    stall = 1'b1;
    wr(ADDR_CTRL, 8'h14);
    rc(ADDR_CTRL, 8'h14);
    idle(40);
    chk(8'(nb), 8'h00);
    stall = 1'b0;
    wait_bytes(NB * CELL_BYTES);
    idle(60);
    chk(8'(nb), 8'(NB * CELL_BYTES));
    chk(8'(ns), 8'(NB));
    chk(hb[0], 8'hA5);
    chk(hb[3], 8'h3C);
    chk(hb[4], 8'hA5 ^ 8'h5A ^ 8'hC3 ^ 8'h3C);
    rc(ADDR_CTRL, 8'h17);
    rc(ADDR_ERR_LO, 8'h00);
    // Lock clears on the edge after the disable, so read one cycle later.
    wr(ADDR_CTRL, 8'h04);
    idle(1);
    rc(ADDR_CTRL, 8'h06);
    // A second burst must clear the done flag left by the first.
    nb = 0;
    ns = 0;
    wr(ADDR_CTRL, 8'h14);
    idle(1);
    rc(ADDR_CTRL, 8'h14);
    wait_bytes(NB * CELL_BYTES);
    idle(60);
    chk(8'(nb), 8'(NB * CELL_BYTES));
    chk(8'(ns), 8'(NB));
    rc(ADDR_CTRL, 8'h17);
    wr(ADDR_CTRL, 8'h04);
    idle(2);
  endtask : t_burst

  task automatic t_cont;
    nb = 0;
    ns = 0;
    wr(ADDR_CTRL, 8'h10);
    idle(1);
    wait_bytes(5 * CELL_BYTES);
    chk(8'(ns), 8'h05);
    rd(ADDR_CTRL, v);
    chk(v & 8'h01, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    idle(80);
  endtask : t_cont

  task automatic t_raw;
    int s0;
    s0 = ns;
    nb = 0;
    wr(ADDR_CTRL, 8'h90);
    idle(1);
    wait_bytes(60);
    rd(ADDR_CTRL, v);
    chk(v & 8'h91, 8'h91);
    chk(8'(ns), 8'(s0));
    rd(ADDR_ERR_HI, v);
    rd(ADDR_ERR_LO, v);
    idle(1);
    flip = 8'h03;
    idle(1);
    flip = 8'h00;
    idle(12);
    rc(ADDR_ERR_HI, 8'h00);
    rc(ADDR_HOLD, 8'h02);
    rc(ADDR_ERR_LO, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    idle(1);
    rd(ADDR_CTRL, v);
    chk(v & 8'h01, 8'h00);
    idle(2);
  endtask : t_raw

  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_regs();
    t_burst();
    t_cont();
    t_raw();
    finish_test();
  end
endmodule : tcp_top_tb
